// *** hw/mixed_axis_fault_response.v ***
// Purpose: fault detection and response for one output axis and one real mode axis
// Assumes: sensor and command inputs come from pins, synchronised here
// Notes: registers at word index; read data one cycle after read strobe
//
// Behaviour
// - output axis out of stroke at real-to-virtual switch: minor 5000, block system start
// - real axis out of stroke: minor 105 at program start, no motion
// - output axis leaves stroke while running: minor 6030, keeps running
// - real axis leaves stroke while running: minor 207, decelerated stop
// - output axis over speed limit: minor 6010, speed not clamped
// - real axis command over speed limit: minor error, speed clamped to limit
// - stop input on output axis: major 11020, continue or clutch on-error mode
// - real axis stop input at start: major 1000, start refused
// - real axis stop input while moving: stop with configured deceleration
// - upper limit inactive on forward output travel: major 11030, clutch behaviour
// - lower limit inactive on reverse output travel: major 11040, clutch behaviour
// - real axis upper limit: 1001 blocks forward start, 1101 stops forward travel
// - real axis lower limit: 1002 blocks reverse start, 1102 stops reverse travel
// - output torque limit follows setting device when selected, except old firmware during switch; else individual change
// - servo-off ignored during real axis positioning; old firmware accepts it in virtual mode
// - old firmware rejects operation, position, speed, torque changes during switch
// - old firmware refuses virtual-to-real switch while real axis positions
// - real axis minor codes 1 to 999, major codes 1000 to 1299
// - output axis codes never written into real axis code stores
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "fault_resp_defs.vh"
module mixed_axis_fault_response #(
   parameter W = 16
) (
   input wire i_clk_sys,
   input wire i_rst_n,
   input wire [3:0] i_addr,
   input wire [W-1:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire i_virtual_mode,
   input wire i_mode_switching,
   input wire i_switch_to_real_req,
   input wire i_out_stroke_ok,
   input wire i_out_running,
   input wire i_out_dir_fwd,
   input wire [W-1:0] i_out_speed,
   input wire i_out_stop,
   input wire i_upper_travel_limit,
   input wire i_lower_travel_limit,
   input wire [W-1:0] i_torque_limit_setting,
   input wire i_torque_limit_individual_change,
   input wire [W-1:0] i_torque_individual_value,
   input wire i_real_stroke_ok,
   input wire i_real_start_req,
   input wire i_real_dir_fwd,
   input wire i_real_done,
   input wire [W-1:0] i_real_cmd_speed,
   input wire i_real_stop,
   input wire i_real_upper_limit,
   input wire i_real_lower_limit,
   input wire i_axis_servo_off_command,
   input wire i_torque_limit_change_request,
   input wire [W-1:0] i_torque_change_value,
   output reg [W-1:0] o_rdata,
   output reg o_out_system_start_block,
   output reg o_out_clutch_off,
   output reg o_out_on_error_stop,
   output reg [W-1:0] o_out_torque_limit,
   output reg o_real_moving,
   output reg o_real_decel,
   output reg o_real_rapid,
   output reg [W-1:0] o_real_speed,
   output reg [W-1:0] o_real_torque_limit,
   output reg o_servo_off,
   output reg o_switch_to_real_ack,
   output reg o_switch_to_real_refused
);
   // reset release
   reg rst_s1_reg;
   reg rst_n_reg;
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_s1_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n_reg <= rst_s1_reg;
      end
   end

   // two-stage pin synchronisers for the single-bit inputs
   localparam NS = 19;
   wire [NS-1:0] pin_raw = {i_torque_limit_change_request, i_virtual_mode, i_mode_switching,
      i_switch_to_real_req, i_out_stroke_ok, i_out_running, i_out_dir_fwd, i_out_stop,
      i_upper_travel_limit, i_lower_travel_limit, i_torque_limit_individual_change,
      i_real_stroke_ok, i_real_start_req, i_real_dir_fwd, i_real_done, i_real_stop,
      i_real_upper_limit, i_real_lower_limit, i_axis_servo_off_command};
   reg [NS-1:0] pin_s1_reg;
   reg [NS-1:0] pin_reg;
   reg [NS-1:0] pin_d_reg;
   // data words sampled alongside (held stable by the source while in use)
   reg [W-1:0] out_speed_reg;
   reg [W-1:0] real_cmd_reg;
   reg [W-1:0] tq_set_reg;
   reg [W-1:0] tq_ind_reg;
   reg [W-1:0] tq_chg_reg;
   always @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         pin_s1_reg <= {NS{1'b0}};
         pin_reg <= {NS{1'b0}};
         pin_d_reg <= {NS{1'b0}};
         out_speed_reg <= {W{1'b0}};
         real_cmd_reg <= {W{1'b0}};
         tq_set_reg <= `TORQUE_RESET_VAL;
         tq_ind_reg <= `TORQUE_RESET_VAL;
         tq_chg_reg <= `TORQUE_RESET_VAL;
      end else begin
         pin_s1_reg <= pin_raw;
         pin_reg <= pin_s1_reg;
         pin_d_reg <= pin_reg;
         out_speed_reg <= i_out_speed;
         real_cmd_reg <= i_real_cmd_speed;
         tq_set_reg <= i_torque_limit_setting;
         tq_ind_reg <= i_torque_individual_value;
         tq_chg_reg <= i_torque_change_value;
      end
   end

   // named views of the synchronised pins
   wire virt = pin_reg[17];
   wire switching = pin_reg[16];
   wire sw_req_rise = pin_reg[15] & ~pin_d_reg[15];
   wire out_stroke_ok = pin_reg[14];
   wire out_run = pin_reg[13];
   wire out_fwd = pin_reg[12];
   wire out_stop_rise = pin_reg[11] & ~pin_d_reg[11];
   wire up_fall = ~pin_reg[10] & pin_d_reg[10];
   wire lo_fall = ~pin_reg[9] & pin_d_reg[9];
   wire tq_ind_rise = pin_reg[8] & ~pin_d_reg[8];
   wire real_stroke_ok = pin_reg[7];
   wire start_rise = pin_reg[6] & ~pin_d_reg[6];
   wire real_fwd = pin_reg[5];
   wire real_done = pin_reg[4];
   wire real_stop = pin_reg[3];
   wire real_up = pin_reg[2];
   wire real_lo = pin_reg[1];
   wire servo_off_cmd = pin_reg[0];
   wire virt_rise = pin_reg[17] & ~pin_d_reg[17];
   wire out_stroke_exit = ~pin_reg[14] & pin_d_reg[14];
   wire chg_rise = pin_reg[18] & ~pin_d_reg[18];

   // software registers
   reg [W-1:0] ctrl_reg;
   reg [W-1:0] speed_lim_reg;
   wire clutch = ctrl_reg[`CTRL_CLUTCH];
   wire old_fw = ctrl_reg[`CTRL_OLD_FW];
   wire frozen = old_fw & switching;
   // outputs of the fault detector
   reg [W-1:0] out_minor_reg;
   reg [W-1:0] out_major_reg;
   reg [W-1:0] real_minor_reg;
   reg [W-1:0] real_major_reg;
   reg [3:0] flags_reg;
   wire wr_flags = i_wr && i_addr == `ADDR_FLAGS;
   wire real_decel_stop = o_real_moving & ~o_real_decel & ~o_real_rapid;
   wire out_err = out_stop_rise | (out_run & out_fwd & up_fall) | (out_run & ~out_fwd & lo_fall);

   // fault detection, response and code latching
   always @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ctrl_reg <= `CTRL_RESET_VAL;
         speed_lim_reg <= `SPEED_LIM_RESET_VAL;
         out_minor_reg <= {W{1'b0}};
         out_major_reg <= {W{1'b0}};
         real_minor_reg <= {W{1'b0}};
         real_major_reg <= {W{1'b0}};
         flags_reg <= 4'h0;
         o_rdata <= {W{1'b0}};
         o_out_system_start_block <= 1'b0;
         o_out_clutch_off <= 1'b0;
         o_out_on_error_stop <= 1'b0;
         o_out_torque_limit <= `TORQUE_RESET_VAL;
         o_real_moving <= 1'b0;
         o_real_decel <= 1'b0;
         o_real_rapid <= 1'b0;
         o_real_speed <= {W{1'b0}};
         o_real_torque_limit <= `TORQUE_RESET_VAL;
         o_servo_off <= 1'b0;
         o_switch_to_real_ack <= 1'b0;
         o_switch_to_real_refused <= 1'b0;
      end else begin
         // register writes; flags clear by writing one, a new event wins
         if (wr_flags) begin
            flags_reg <= flags_reg & ~i_wdata[3:0];
         end
         if (i_wr && i_addr == `ADDR_CTRL) begin
            ctrl_reg <= i_wdata;
         end
         if (i_wr && i_addr == `ADDR_SPEED_LIM && !frozen) begin
            speed_lim_reg <= i_wdata;
         end
         // read port, one cycle latency
         if (i_rd) begin
            if (i_addr == `ADDR_CTRL) begin
               o_rdata <= ctrl_reg;
            end else if (i_addr == `ADDR_STAT) begin
               o_rdata <= {{(W-7){1'b0}}, o_servo_off, o_real_rapid, o_real_decel,
                  o_real_moving, o_out_on_error_stop, o_out_clutch_off,
                  o_out_system_start_block};
            end else if (i_addr == `ADDR_OUT_MINOR) begin
               o_rdata <= out_minor_reg;
            end else if (i_addr == `ADDR_OUT_MAJOR) begin
               o_rdata <= out_major_reg;
            end else if (i_addr == `ADDR_REAL_MINOR) begin
               o_rdata <= real_minor_reg;
            end else if (i_addr == `ADDR_REAL_MAJOR) begin
               o_rdata <= real_major_reg;
            end else if (i_addr == `ADDR_TORQUE) begin
               o_rdata <= o_out_torque_limit;
            end else if (i_addr == `ADDR_SPEED_LIM) begin
               o_rdata <= speed_lim_reg;
            end else if (i_addr == `ADDR_FLAGS) begin
               o_rdata <= {{(W-4){1'b0}}, flags_reg};
            end else begin
               o_rdata <= {W{1'b0}};
            end
         end
         // output axis stroke at switch and while running
         if (virt_rise && !out_stroke_ok) begin
            out_minor_reg <= `ERR_OUT_STROKE_SWITCH;
            flags_reg[0] <= 1'b1;
            o_out_system_start_block <= 1'b1;
         end else if (out_run && out_stroke_exit) begin
            out_minor_reg <= `ERR_OUT_STROKE_RUN;
            flags_reg[0] <= 1'b1;
         end else if (out_run && out_speed_reg > speed_lim_reg) begin
            out_minor_reg <= `ERR_OUT_SPEED;
            flags_reg[0] <= 1'b1;
         end
         if (!virt) begin
            o_out_system_start_block <= 1'b0;
         end
         // output axis major: codes kept apart from real stores
         if (out_stop_rise) begin
            out_major_reg <= `ERR_OUT_STOP;
         end else if (out_run && out_fwd && up_fall) begin
            out_major_reg <= `ERR_OUT_UPPER;
         end else if (out_run && !out_fwd && lo_fall) begin
            out_major_reg <= `ERR_OUT_LOWER;
         end
         // no clutch: axis keeps going; clutch: follow on-error mode
         if (out_err) begin
            flags_reg[1] <= 1'b1;
            if (clutch && ctrl_reg[`CTRL_ON_ERR_CLUTCH_OFF]) begin
               o_out_clutch_off <= 1'b1;
            end else if (clutch) begin
               o_out_on_error_stop <= 1'b1;
            end
         end else if (!out_run) begin
            o_out_clutch_off <= 1'b0;
            o_out_on_error_stop <= 1'b0;
         end
         // output axis torque: setting device, else individual change
         if (!frozen) begin
            if (ctrl_reg[`CTRL_TORQUE_DEV_SET]) begin
               o_out_torque_limit <= tq_set_reg;
            end else if (tq_ind_rise) begin
               o_real_torque_limit <= tq_ind_reg;
               o_out_torque_limit <= tq_ind_reg;
            end else if (chg_rise) begin
               o_real_torque_limit <= tq_chg_reg;
            end
         end
         // real mode axis start checks
         if (start_rise && !o_real_moving && !frozen) begin
            if (!real_stroke_ok) begin
               real_minor_reg <= `ERR_REAL_STROKE_START;
               flags_reg[2] <= 1'b1;
            end else if (real_stop) begin
               real_major_reg <= `ERR_REAL_STOP_START;
               flags_reg[3] <= 1'b1;
            end else if (real_fwd && !real_up) begin
               real_major_reg <= `ERR_REAL_UPPER_START;
               flags_reg[3] <= 1'b1;
            end else if (!real_fwd && !real_lo) begin
               real_major_reg <= `ERR_REAL_LOWER_START;
               flags_reg[3] <= 1'b1;
            end else begin
               o_real_moving <= 1'b1;
               if (real_cmd_reg > speed_lim_reg) begin
                  o_real_speed <= speed_lim_reg;
                  real_minor_reg <= `ERR_REAL_SPEED;
                  flags_reg[2] <= 1'b1;
               end else begin
                  o_real_speed <= real_cmd_reg;
               end
            end
         end else if (real_decel_stop) begin
            // running faults on the real axis
            if (!real_stroke_ok) begin
               real_minor_reg <= `ERR_REAL_STROKE_RUN;
               flags_reg[2] <= 1'b1;
               o_real_decel <= 1'b1;
            end else if (real_stop) begin
               o_real_decel <= ~ctrl_reg[`CTRL_DECEL_RAPID];
               o_real_rapid <= ctrl_reg[`CTRL_DECEL_RAPID];
            end else if (real_fwd ? !real_up : !real_lo) begin
               real_major_reg <= real_fwd ? `ERR_REAL_UPPER_RUN : `ERR_REAL_LOWER_RUN;
               flags_reg[3] <= 1'b1;
               o_real_decel <= ~ctrl_reg[`CTRL_DECEL_RAPID];
               o_real_rapid <= ctrl_reg[`CTRL_DECEL_RAPID];
            end else if (real_done) begin
               o_real_moving <= 1'b0;
            end
         end else if (o_real_moving && real_done) begin
            o_real_moving <= 1'b0;
            o_real_decel <= 1'b0;
            o_real_rapid <= 1'b0;
            o_real_speed <= {W{1'b0}};
         end
         // servo-off: ignored while positioning unless old firmware in virtual mode
         if (!servo_off_cmd) begin
            o_servo_off <= 1'b0;
         end else if (!o_real_moving || (virt && old_fw)) begin
            o_servo_off <= 1'b1;
         end
         // virtual-to-real switch request
         o_switch_to_real_ack <= 1'b0;
         o_switch_to_real_refused <= 1'b0;
         if (sw_req_rise) begin
            if (old_fw && o_real_moving) begin
               o_switch_to_real_refused <= 1'b1;
            end else begin
               o_switch_to_real_ack <= 1'b1;
            end
         end
      end
   end
endmodule // mixed_axis_fault_response

// *** hw/fault_resp_defs.vh ***
// Purpose: constants for the mixed-axis fault response block
// Assumes: one control-cycle clock, plain register port
// Notes: error codes are decimal values carried in 16-bit fields
`ifndef FAULT_RESP_DEFS_VH
`define FAULT_RESP_DEFS_VH
// register offsets
`define ADDR_CTRL 4'h0
`define ADDR_STAT 4'h1
`define ADDR_OUT_MINOR 4'h2
`define ADDR_OUT_MAJOR 4'h3
`define ADDR_REAL_MINOR 4'h4
`define ADDR_REAL_MAJOR 4'h5
`define ADDR_TORQUE 4'h6
`define ADDR_SPEED_LIM 4'h7
`define ADDR_FLAGS 4'h8
// control register fields
`define CTRL_CLUTCH 0
`define CTRL_ON_ERR_CLUTCH_OFF 1
`define CTRL_DECEL_RAPID 2
`define CTRL_OLD_FW 3
`define CTRL_TORQUE_DEV_SET 4
`define CTRL_RESET_VAL 16'h0000
`define TORQUE_RESET_VAL 16'h012C
`define SPEED_LIM_RESET_VAL 16'hFFFF
// error codes
`define ERR_OUT_STROKE_SWITCH 16'h1388
`define ERR_REAL_STROKE_START 16'h0069
`define ERR_OUT_STROKE_RUN 16'h178E
`define ERR_REAL_STROKE_RUN 16'h00CF
`define ERR_OUT_SPEED 16'h177A
`define ERR_REAL_SPEED 16'h0033
`define ERR_OUT_STOP 16'h2B0C
`define ERR_REAL_STOP_START 16'h03E8
`define ERR_OUT_UPPER 16'h2B16
`define ERR_OUT_LOWER 16'h2B20
`define ERR_REAL_UPPER_START 16'h03E9
`define ERR_REAL_LOWER_START 16'h03EA
`define ERR_REAL_UPPER_RUN 16'h044D
`define ERR_REAL_LOWER_RUN 16'h044E
`endif

// *** tb/mixed_axis_fault_response_monitor.sv ***
// Purpose: port checker for mixed_axis_fault_response
// Assumes: control and speed limit written only while axes idle
// Notes: helper regs mirror host writes
`timescale 1ns/10ps
module mixed_axis_fault_response_monitor #(
   parameter W = 16
) (
   input wire i_clk_sys,
   input wire i_rst_n,
   input wire [3:0] i_addr,
   input wire [W-1:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire i_out_running,
   input wire i_out_stop,
   input wire [W-1:0] i_torque_limit_setting,
   input wire i_real_stroke_ok,
   input wire i_real_dir_fwd,
   input wire i_real_stop,
   input wire i_real_upper_limit,
   input wire i_real_lower_limit,
   input wire [W-1:0] o_rdata,
   input wire o_out_clutch_off,
   input wire o_out_on_error_stop,
   input wire [W-1:0] o_out_torque_limit,
   input wire o_real_moving,
   input wire o_real_decel,
   input wire o_real_rapid,
   input wire [W-1:0] o_real_speed,
   input wire o_servo_off,
   input wire o_switch_to_real_refused
);
   reg [4:0] ctrl_q;
   reg [W-1:0] lim_q;
   // mirror of control and speed limit writes
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_q <= 5'h00;
         lim_q <= {W{1'b1}};
      end else if (i_wr) begin
         if (i_addr == 4'h0) ctrl_q <= i_wdata[4:0];
         if (i_addr == 4'h7 && !ctrl_q[3]) lim_q <= i_wdata;
      end
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   AST_REAL_MINOR_RANGE: assert property (i_rd && i_addr == 4'h4 |=> o_rdata <= 16'h03E7)
      else $error("real minor code out of range");
   AST_REAL_MAJOR_RANGE: assert property (i_rd && i_addr == 4'h5 |=>
      o_rdata == 16'h0000 || (o_rdata >= 16'h03E8 && o_rdata <= 16'h0513))
      else $error("real major code out of range");
   AST_START_STOP: assert property ($rose(o_real_moving) |-> !$past(i_real_stop, 3))
      else $error("start taken with stop input on");
   AST_START_STROKE: assert property ($rose(o_real_moving) |-> $past(i_real_stroke_ok, 3))
      else $error("start taken out of stroke");
   AST_START_LIMIT: assert property ($rose(o_real_moving) |-> ($past(i_real_dir_fwd, 3) ?
      $past(i_real_upper_limit, 3) : $past(i_real_lower_limit, 3)))
      else $error("start taken with travel limit off");
   AST_RUN_STOP: assert property ((o_real_moving && i_real_stop) [*4] |->
      ##[0:8] ((ctrl_q[2] ? o_real_rapid : o_real_decel) || !o_real_moving))
      else $error("moving axis ignores stop input");
   AST_SPEED_CLAMP: assert property (o_real_moving && $past(o_real_moving) |->
      o_real_speed <= lim_q)
      else $error("real speed above limit");
   AST_SERVO_OFF: assert property ($rose(o_servo_off) |-> ctrl_q[3] ||
      !$past(o_real_moving))
      else $error("servo off taken while positioning");
   AST_NO_CLUTCH: assert property (!ctrl_q[0] |-> !o_out_clutch_off && !o_out_on_error_stop)
      else $error("clutch response without clutch");
   AST_CLUTCH_OFF: assert property (ctrl_q[1:0] == 2'b11 && i_out_running &&
      $rose(i_out_stop) |-> ##[1:8] o_out_clutch_off)
      else $error("clutch not released on stop");
   AST_TORQUE_FOLLOW: assert property (ctrl_q[4] && !ctrl_q[3] &&
      $changed(i_torque_limit_setting) ##1 (ctrl_q[4] && $stable(i_torque_limit_setting)) [*5]
      |-> o_out_torque_limit == i_torque_limit_setting)
      else $error("torque limit does not follow setting");
   // main scenarios reached
   cover property ($rose(o_real_moving));
   cover property ($rose(o_out_clutch_off));
   cover property ($rose(o_real_decel));
   cover property (o_switch_to_real_refused);
endmodule // mixed_axis_fault_response_monitor
bind mixed_axis_fault_response mixed_axis_fault_response_monitor #(.W(W)) mon (.*);

// *** tb/axis_far_side.sv ***
// Purpose: real axis switches and stroke state beside the block
// Assumes: fault pattern commanded by the bench
// Notes: stroke stays lost until jogged back inside
`timescale 1ns/10ps
module axis_far_side (
   input wire i_clk_sys,
   input wire [3:0] i_fault,
   input wire i_jog_back,
   output reg o_stop = 1'b0,
   output reg o_upper_ok = 1'b1,
   output reg o_lower_ok = 1'b1,
   output reg o_stroke_ok = 1'b1
);
   // switch levels follow the fault pattern
   always @(posedge i_clk_sys) begin
      o_stop <= i_fault[0];
      o_upper_ok <= !i_fault[1];
      o_lower_ok <= !i_fault[2];
      if (i_fault[3]) o_stroke_ok <= 1'b0;
      else if (i_jog_back) o_stroke_ok <= 1'b1;
   end
endmodule // axis_far_side

// *** tb/mixed_axis_fault_response_test.sv ***
// Purpose: self-checking bench for mixed_axis_fault_response
// Assumes: 25 MHz clock, pins take three edges to act
// Notes: read results checked from a queue at the falling edge
`timescale 1ns/10ps
`include "fault_resp_defs.vh"
module mixed_axis_fault_response_test;
   logic i_clk_sys = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, rd_q = 0, jog = 0, k;
   logic [3:0] i_addr = 0, flt = 0;
   logic [15:0] i_wdata = 0, i_out_speed = 0, i_torque_limit_setting = 0, r = 16'd17880;
   logic [15:0] i_torque_individual_value = 0, i_real_cmd_speed = 16'h0010;
   logic [15:0] i_torque_change_value = 0;
   logic i_virtual_mode = 0, i_mode_switching = 0, i_switch_to_real_req = 0;
   logic i_out_stroke_ok = 1, i_out_running = 0, i_out_dir_fwd = 1, i_out_stop = 0;
   logic i_upper_travel_limit = 1, i_lower_travel_limit = 1, i_real_start_req = 0;
   logic i_torque_limit_individual_change = 0, i_real_dir_fwd = 1, i_real_done = 0;
   logic i_axis_servo_off_command = 0, i_torque_limit_change_request = 0;
   wire i_real_stroke_ok, i_real_stop, i_real_upper_limit, i_real_lower_limit;
   wire [15:0] o_rdata, o_out_torque_limit, o_real_speed, o_real_torque_limit;
   wire o_out_system_start_block, o_out_clutch_off, o_out_on_error_stop, o_real_moving;
   wire o_real_decel, o_real_rapid, o_servo_off, o_switch_to_real_ack, o_switch_to_real_refused;
   logic [15:0] eq[$];
   int n_mismatch = 0, checks = 0;
   mixed_axis_fault_response uut (.*);
   axis_far_side far (.i_clk_sys(i_clk_sys), .i_fault(flt), .i_jog_back(jog),
      .o_stop(i_real_stop), .o_upper_ok(i_real_upper_limit),
      .o_lower_ok(i_real_lower_limit), .o_stroke_ok(i_real_stroke_ok));
   always #20 i_clk_sys = ~i_clk_sys;
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk_sys);
      i_wr <= 1; i_addr <= a; i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge i_clk_sys);
      i_rd <= 1; i_addr <= a; eq.push_back(e);
      @(posedge i_clk_sys);
      i_rd <= 0;
   endtask
   task automatic start();
      @(posedge i_clk_sys);
      i_real_start_req <= 1; cyc(4); i_real_start_req <= 0; cyc(4);
   endtask
   task automatic settle();
      @(posedge i_clk_sys);
      i_real_done <= 1; flt <= 0; jog <= 1; cyc(5);
      i_real_done <= 0; jog <= 0; cyc(4);
      wr(`ADDR_FLAGS, 16'h000F);
   endtask
   task summarize;
      if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // read data watcher
   always @(posedge i_clk_sys) rd_q <= i_rd;
   always @(negedge i_clk_sys) if (rd_q) chk(o_rdata, eq.pop_front());
   initial begin
      #400000;
      n_mismatch++;
      summarize();
   end
   logic [3:0] cf[4] = '{4'h1, 4'h2, 4'h4, 4'h8};
   logic [15:0] cc[4] = '{`ERR_REAL_STOP_START, `ERR_REAL_UPPER_START,
      `ERR_REAL_LOWER_START, `ERR_REAL_STROKE_START};
   logic [3:0] rf[4] = '{4'h2, 4'h4, 4'h8, 4'h1};
   logic [15:0] rc[4] = '{`ERR_REAL_UPPER_RUN, `ERR_REAL_LOWER_RUN, `ERR_REAL_STROKE_RUN, 16'h0};
   logic [15:0] oc[3] = '{`ERR_OUT_STOP, `ERR_OUT_UPPER, `ERR_OUT_LOWER};
   // main sequence
   initial begin
      cyc(16); i_rst_n <= 1; cyc(4);
      @(negedge i_clk_sys) chk(o_real_torque_limit, `TORQUE_RESET_VAL);
      rd(`ADDR_CTRL, `CTRL_RESET_VAL);
      rd(`ADDR_TORQUE, `TORQUE_RESET_VAL);
      rd(`ADDR_SPEED_LIM, `SPEED_LIM_RESET_VAL);
      rd(4'hF, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         flt <= cf[i]; i_real_dir_fwd <= !cf[i][2]; cyc(6); start();
         @(negedge i_clk_sys) chk(o_real_moving, 0);
         rd(i == 3 ? `ADDR_REAL_MINOR : `ADDR_REAL_MAJOR, cc[i]);
         rd(`ADDR_FLAGS, i == 3 ? 16'h0004 : 16'h0008);
         settle();
         rd(`ADDR_FLAGS, 16'h0000);
      end
      for (int i = 0; i < 4; i++) begin
         wr(`ADDR_CTRL, i == 3 ? 16'h0004 : 16'h0000);
         i_real_dir_fwd <= !rf[i][2]; start();
         @(negedge i_clk_sys) chk(o_real_moving, 1);
         @(posedge i_clk_sys) flt <= rf[i]; cyc(8);
         @(negedge i_clk_sys) chk({o_real_decel, o_real_rapid}, i == 3 ? 1 : 2);
         chk(o_real_moving, 1);
         if (i < 3) rd(i == 2 ? `ADDR_REAL_MINOR : `ADDR_REAL_MAJOR, rc[i]);
         settle();
      end
      wr(`ADDR_SPEED_LIM, 16'h0100);
      r = lfsr(r); i_real_cmd_speed <= r | 16'h8000; start();
      @(negedge i_clk_sys) chk(o_real_speed, 16'h0100);
      rd(`ADDR_REAL_MINOR, `ERR_REAL_SPEED);
      i_axis_servo_off_command <= 1; cyc(6);
      @(negedge i_clk_sys) chk(o_servo_off, 0);
      settle();
      @(negedge i_clk_sys) chk(o_servo_off, 1);
      @(posedge i_clk_sys) i_axis_servo_off_command <= 0; i_out_stroke_ok <= 0; cyc(4);
      i_virtual_mode <= 1; cyc(6);
      @(negedge i_clk_sys) chk(o_out_system_start_block, 1);
      rd(`ADDR_OUT_MINOR, `ERR_OUT_STROKE_SWITCH);
      rd(`ADDR_REAL_MINOR, `ERR_REAL_SPEED);
      i_out_stroke_ok <= 1; i_virtual_mode <= 0; cyc(6);
      @(negedge i_clk_sys) chk(o_out_system_start_block, 0);
      @(posedge i_clk_sys) i_virtual_mode <= 1;
      wr(`ADDR_CTRL, 16'h0003);
      @(posedge i_clk_sys) i_out_running <= 1; cyc(6); i_out_stroke_ok <= 0; cyc(6);
      @(negedge i_clk_sys) chk({o_out_clutch_off, o_out_on_error_stop}, 0);
      rd(`ADDR_OUT_MINOR, `ERR_OUT_STROKE_RUN);
      wr(`ADDR_SPEED_LIM, 16'h0200);
      i_out_stroke_ok <= 1; i_out_speed <= 16'h0300; cyc(6);
      rd(`ADDR_OUT_MINOR, `ERR_OUT_SPEED);
      @(posedge i_clk_sys) i_out_running <= 0; cyc(6);
      for (int i = 0; i < 3; i++) begin
         wr(`ADDR_CTRL, i == 0 ? 16'h0003 : i == 1 ? 16'h0001 : 16'h0000);
         @(posedge i_clk_sys) i_out_dir_fwd <= i != 2; i_out_running <= 1; cyc(6);
         i_out_stop <= i == 0; i_upper_travel_limit <= i != 1; i_lower_travel_limit <= i != 2;
         cyc(8);
         @(negedge i_clk_sys) chk({o_out_clutch_off, o_out_on_error_stop}, 2 >> i);
         rd(`ADDR_OUT_MAJOR, oc[i]);
         rd(`ADDR_REAL_MAJOR, `ERR_REAL_LOWER_RUN);
         i_out_running <= 0; i_out_stop <= 0; i_upper_travel_limit <= 1;
         i_lower_travel_limit <= 1; cyc(8);
      end
      wr(`ADDR_CTRL, 16'h0010);
      r = lfsr(r); i_torque_limit_setting <= r; cyc(8);
      @(negedge i_clk_sys) chk(o_out_torque_limit, r);
      wr(`ADDR_CTRL, 16'h0000);
      r = lfsr(r); i_torque_individual_value <= r; i_torque_limit_individual_change <= 1;
      cyc(5); i_torque_limit_individual_change <= 0; cyc(4);
      @(negedge i_clk_sys) chk(o_out_torque_limit, r);
      @(posedge i_clk_sys) r = lfsr(r);
      i_torque_change_value <= r; i_torque_limit_change_request <= 1;
      cyc(5); i_torque_limit_change_request <= 0; cyc(4);
      @(negedge i_clk_sys) chk(o_real_torque_limit, r);
      wr(`ADDR_CTRL, 16'h0008); start();
      i_switch_to_real_req <= 1; k = 0;
      repeat (10) @(negedge i_clk_sys) if (o_switch_to_real_refused === 1'b1) k = 1;
      chk(k, 1);
      @(posedge i_clk_sys) i_switch_to_real_req <= 0; i_mode_switching <= 1; cyc(4);
      wr(`ADDR_SPEED_LIM, 16'h1234);
      rd(`ADDR_SPEED_LIM, 16'h0200);
      i_axis_servo_off_command <= 1; cyc(6);
      @(negedge i_clk_sys) chk(o_servo_off, 1);
      settle();
      i_switch_to_real_req <= 1; k = 0;
      repeat (10) @(negedge i_clk_sys) if (o_switch_to_real_ack === 1'b1) k = 1;
      chk(k, 1);
      summarize();
   end
endmodule // mixed_axis_fault_response_test
